// >>> inc/slie_pkg.sv
`default_nettype none
package slie_pkg;
    localparam int NUM_LINKS = 2;
    localparam int LINK_W    = 1;
    localparam int ADDR_W    = 12;
    localparam int ILAS_LEN  = 14;

    localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE = 12'h300;
    localparam logic [ADDR_W-1:0] ADDR_ILAS_BASE = 12'h450;
    localparam logic [ADDR_W-1:0] ADDR_ILAS_CKS  = 12'h45D;
    localparam logic [ADDR_W-1:0] ADDR_EN_A      = 12'h4B8;
    localparam logic [ADDR_W-1:0] ADDR_EN_B      = 12'h4B9;
    localparam logic [ADDR_W-1:0] ADDR_ST_A      = 12'h4BA;
    localparam logic [ADDR_W-1:0] ADDR_ST_B      = 12'h4BB;
    localparam logic [ADDR_W-1:0] ADDR_PIN_SEL   = 12'h4BC;

    localparam int BIT_BDE      = 7;
    localparam int BIT_NIT      = 6;
    localparam int BIT_UEK      = 5;
    localparam int BIT_ILD      = 4;
    localparam int BIT_ILS      = 3;
    localparam int BIT_CKS      = 2;
    localparam int BIT_FS       = 1;
    localparam int BIT_CGS      = 0;
    localparam int BIT_CFG      = 0;
    localparam int BIT_PIN_SEL  = 0;

    localparam logic [3:0] ILAS_CKS_IDX = 4'hD;
    localparam logic [2:0] LANE_CHECKED = 3'h0;

    localparam logic [7:0]        RST_EN_A    = 8'h00;
    localparam logic              RST_EN_B    = 1'b0;
    localparam logic [7:0]        RST_ST_A    = 8'h00;
    localparam logic              RST_ST_B    = 1'b0;
    localparam logic [LINK_W-1:0] RST_PAGE    = 1'b0;
    localparam logic              RST_PIN_SEL = 1'b0;
    localparam logic [7:0]        RST_ILAS    = 8'h00;

    typedef logic [ILAS_LEN-1:0][7:0] slie_ilas_t;

    // Sum of all parameter bytes below the checksum byte, modulo 256
    function automatic logic [7:0] slie_cks_sum(input slie_ilas_t b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < ILAS_LEN - 1; i++) begin
            s = s + b[i];
        end
        return s;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/slie_ilas_check.sv
`timescale 1ns/1ns
`default_nettype none
module slie_ilas_check (
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         ilas_valid_in,
    input  wire logic [2:0]                   ilas_lane_in,
    input  wire logic [slie_pkg::LINK_W-1:0]  ilas_link_in,
    input  wire logic [3:0]                   ilas_index_in,
    input  wire logic [7:0]                   ilas_byte_in,
    input  wire logic                         ilas_done_in,
    input  wire slie_pkg::slie_ilas_t         prog_in,
    output logic                              cks_good_out,
    output logic                              cfg_mismatch_out,
    output logic [slie_pkg::LINK_W-1:0]       event_link_out
);
    import slie_pkg::*;

    slie_ilas_t          rx_r, rx_nxt;
    logic                cks_r, cks_nxt;
    logic                mis_r, mis_nxt;
    logic [LINK_W-1:0]   link_r, link_nxt;
    logic                lane_ok;

    always_comb begin
        lane_ok  = ilas_lane_in == LANE_CHECKED;
        rx_nxt   = rx_r;
        cks_nxt  = 1'b0;
        mis_nxt  = 1'b0;
        link_nxt = link_r;
        if (ilas_valid_in && lane_ok && ilas_index_in <= ILAS_CKS_IDX) begin
            rx_nxt[ilas_index_in] = ilas_byte_in;
        end
        if (ilas_done_in && lane_ok) begin
            cks_nxt  = slie_cks_sum(rx_r) == rx_r[ILAS_CKS_IDX];
            mis_nxt  = rx_r != prog_in;
            link_nxt = ilas_link_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_r   <= '0;
            cks_r  <= 1'b0;
            mis_r  <= 1'b0;
            link_r <= '0;
        end else begin
            rx_r   <= rx_nxt;
            cks_r  <= cks_nxt;
            mis_r  <= mis_nxt;
            link_r <= link_nxt;
        end
    end

    assign cks_good_out     = cks_r;
    assign cfg_mismatch_out = mis_r;
    assign event_link_out   = link_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_done;
        ilas_done_in && lane_ok;
    endsequence

    property p_cks_match;
        s_done ##0 (slie_cks_sum(rx_r) == rx_r[ILAS_CKS_IDX]) |=> cks_good_out;
    endproperty
    a_cks_match: assert property (p_cks_match) else $error("good checksum missed");

    property p_cks_ignores_prog;
        s_done ##0 (slie_cks_sum(rx_r) != rx_r[ILAS_CKS_IDX])
            ##0 (slie_cks_sum(rx_r) == prog_in[ILAS_CKS_IDX]) |=> !cks_good_out;
    endproperty
    a_cks_ignores_prog: assert property (p_cks_ignores_prog)
        else $error("checksum used programmed value");

    property p_mismatch;
        s_done ##0 (rx_r != prog_in) |=> cfg_mismatch_out && event_link_out == $past(ilas_link_in);
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

    property p_cks_compared;
        s_done ##0 (rx_r[ILAS_CKS_IDX] != prog_in[ILAS_CKS_IDX]) |=> cfg_mismatch_out;
    endproperty
    a_cks_compared: assert property (p_cks_compared) else $error("checksum not compared");

    property p_lane0_only;
        (ilas_valid_in || ilas_done_in) && !lane_ok
            |=> $stable(rx_r) && !cks_good_out && !cfg_mismatch_out;
    endproperty
    a_lane0_only: assert property (p_lane0_only) else $error("non-zero lane checked");
endmodule // slie_ilas_check
`default_nettype wire

// >>> rtl/slie_irq_core.sv
`timescale 1ns/1ns
`default_nettype none
module slie_irq_core (
    input  wire logic                                         clk_in,
    input  wire logic                                         rst_n_in,
    input  wire logic                                         reg_wr_in,
    input  wire logic                                         reg_rd_in,
    input  wire logic [slie_pkg::ADDR_W-1:0]                  reg_addr_in,
    input  wire logic [7:0]                                   reg_wdata_in,
    output logic      [7:0]                                   reg_rdata_out,
    output logic                                              reg_rvalid_out,
    input  wire logic [7:0]                                   error_count_threshold_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0][7:0]          bde_count_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0][7:0]          nit_count_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0][7:0]          uek_count_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0]               deskew_ok_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0]               lane_sync_ok_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0]               frame_sync_ok_in,
    input  wire logic [slie_pkg::NUM_LINKS-1:0]               codegroup_sync_ok_in,
    input  wire logic                                         ilas_valid_in,
    input  wire logic [2:0]                                   ilas_lane_in,
    input  wire logic [slie_pkg::LINK_W-1:0]                  ilas_link_in,
    input  wire logic [3:0]                                   ilas_index_in,
    input  wire logic [7:0]                                   ilas_byte_in,
    input  wire logic                                         ilas_done_in,
    output logic                                              interrupt_pin_first_out,
    output logic                                              interrupt_pin_second_out
);
    import slie_pkg::*;

    logic [LINK_W-1:0]                  page_r, page_nxt;
    logic                               pin_sel_r, pin_sel_nxt;
    logic [NUM_LINKS-1:0][7:0]          en_a_r, en_a_nxt;
    logic [NUM_LINKS-1:0][7:0]          st_a_r, st_a_nxt;
    logic [NUM_LINKS-1:0][7:0]          lvl_r, lvl;
    logic [NUM_LINKS-1:0]               en_b_r, en_b_nxt;
    logic [NUM_LINKS-1:0]               st_b_r, st_b_nxt;
    slie_ilas_t [NUM_LINKS-1:0]         prog_r, prog_nxt;
    logic [7:0]                         rdata_r, rdata_nxt;
    logic                               rvalid_r;
    logic                               first_r, first_nxt;
    logic                               second_r, second_nxt;
    logic [NUM_LINKS-1:0][7:0]          ev_a;
    logic [NUM_LINKS-1:0]               ev_b;
    logic                               cks_good;
    logic                               cfg_bad;
    logic [LINK_W-1:0]                  ev_link;
    logic                               irq_any;

    function automatic logic ilas_hit(input logic [ADDR_W-1:0] a);
        return a >= ADDR_ILAS_BASE && a <= ADDR_ILAS_CKS;
    endfunction

    function automatic logic [3:0] ilas_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - ADDR_ILAS_BASE;
        return d[3:0];
    endfunction

    slie_ilas_check u_ilas_check (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .ilas_valid_in    (ilas_valid_in),
        .ilas_lane_in     (ilas_lane_in),
        .ilas_link_in     (ilas_link_in),
        .ilas_index_in    (ilas_index_in),
        .ilas_byte_in     (ilas_byte_in),
        .ilas_done_in     (ilas_done_in),
        .prog_in          (prog_r[ilas_link_in]),
        .cks_good_out     (cks_good),
        .cfg_mismatch_out (cfg_bad),
        .event_link_out   (ev_link)
    );

    // Source levels, rising-edge events and alignment-check (checksum, mismatch) events per link
    always_comb begin
        for (int l = 0; l < NUM_LINKS; l++) begin
            lvl[l]          = 8'h00;
            lvl[l][BIT_BDE] = bde_count_in[l] >= error_count_threshold_in;
            lvl[l][BIT_NIT] = nit_count_in[l] >= error_count_threshold_in;
            lvl[l][BIT_UEK] = uek_count_in[l] >= error_count_threshold_in;
            lvl[l][BIT_ILD] = deskew_ok_in[l];
            lvl[l][BIT_ILS] = lane_sync_ok_in[l];
            lvl[l][BIT_FS]  = frame_sync_ok_in[l];
            lvl[l][BIT_CGS] = codegroup_sync_ok_in[l];
            ev_a[l]          = lvl[l] & ~lvl_r[l];
            ev_a[l][BIT_CKS] = cks_good && ev_link == LINK_W'(l);
            ev_b[l]          = cfg_bad && ev_link == LINK_W'(l);
        end
    end

    // Register writes, sticky status, readback
    always_comb begin
        page_nxt    = page_r;
        pin_sel_nxt = pin_sel_r;
        en_a_nxt    = en_a_r;
        en_b_nxt    = en_b_r;
        st_a_nxt    = st_a_r;
        st_b_nxt    = st_b_r;
        prog_nxt    = prog_r;
        rdata_nxt   = rdata_r;
        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_LINK_PAGE: page_nxt = reg_wdata_in[LINK_W-1:0];
                ADDR_EN_A:      en_a_nxt[page_r] = reg_wdata_in;
                ADDR_EN_B:      en_b_nxt[page_r] = reg_wdata_in[BIT_CFG];
                ADDR_ST_A:      st_a_nxt[page_r] = st_a_r[page_r] & ~reg_wdata_in;
                ADDR_ST_B: begin
                    st_b_nxt[page_r] = st_b_r[page_r] & ~reg_wdata_in[BIT_CFG];
                end
                ADDR_PIN_SEL:   pin_sel_nxt = reg_wdata_in[BIT_PIN_SEL];
                default: begin
                    if (ilas_hit(reg_addr_in)) begin
                        prog_nxt[page_r][ilas_idx(reg_addr_in)] = reg_wdata_in;
                    end
                end
            endcase
        end
        // Set wins over a same-cycle clear
        for (int l = 0; l < NUM_LINKS; l++) begin
            st_a_nxt[l] = st_a_nxt[l] | (ev_a[l] & en_a_r[l]);
            st_b_nxt[l] = st_b_nxt[l] | (ev_b[l] & en_b_r[l]);
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_LINK_PAGE: rdata_nxt = {{(8-LINK_W){1'b0}}, page_r};
                ADDR_EN_A:      rdata_nxt = en_a_r[page_r];
                ADDR_EN_B:      rdata_nxt = {7'h00, en_b_r[page_r]};
                ADDR_ST_A:      rdata_nxt = st_a_r[page_r];
                ADDR_ST_B:      rdata_nxt = {7'h00, st_b_r[page_r]};
                ADDR_PIN_SEL:   rdata_nxt = {7'h00, pin_sel_r};
                default: begin
                    if (ilas_hit(reg_addr_in)) begin
                        rdata_nxt = prog_r[page_r][ilas_idx(reg_addr_in)];
                    end else begin
                        rdata_nxt = 8'h00;
                    end
                end
            endcase
        end
        irq_any    = |(st_a_r & en_a_r) || |(st_b_r & en_b_r);
        first_nxt  = irq_any && !pin_sel_r;
        second_nxt = irq_any && pin_sel_r;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            page_r    <= RST_PAGE;
            pin_sel_r <= RST_PIN_SEL;
            en_a_r    <= {NUM_LINKS{RST_EN_A}};
            en_b_r    <= {NUM_LINKS{RST_EN_B}};
            st_a_r    <= {NUM_LINKS{RST_ST_A}};
            st_b_r    <= {NUM_LINKS{RST_ST_B}};
            prog_r    <= {(NUM_LINKS*ILAS_LEN){RST_ILAS}};
            lvl_r     <= '0;
            rdata_r   <= 8'h00;
            rvalid_r  <= 1'b0;
            first_r   <= 1'b0;
            second_r  <= 1'b0;
        end else begin
            page_r    <= page_nxt;
            pin_sel_r <= pin_sel_nxt;
            en_a_r    <= en_a_nxt;
            en_b_r    <= en_b_nxt;
            st_a_r    <= st_a_nxt;
            st_b_r    <= st_b_nxt;
            prog_r    <= prog_nxt;
            lvl_r     <= lvl;
            rdata_r   <= rdata_nxt;
            rvalid_r  <= reg_rd_in;
            first_r   <= first_nxt;
            second_r  <= second_nxt;
        end
    end

    assign reg_rdata_out            = rdata_r;
    assign reg_rvalid_out           = rvalid_r;
    assign interrupt_pin_first_out  = first_r;
    assign interrupt_pin_second_out = second_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wr_en_a_page0;
        reg_wr_in && reg_addr_in == ADDR_EN_A && page_r == '0;
    endsequence

    property p_banked;
        s_wr_en_a_page0 |=> en_a_r[0] == $past(reg_wdata_in) && $stable(en_a_r[1]);
    endproperty
    a_banked: assert property (p_banked) else $error("enable write hit wrong bank");

    sequence s_ild_rise0;
        en_a_r[0][BIT_ILD] && deskew_ok_in[0] && !lvl_r[0][BIT_ILD];
    endsequence

    property p_map;
        s_ild_rise0 |=> st_a_r[0][BIT_ILD] && (st_a_r[0][BIT_BDE] == $past(st_a_r[0][BIT_BDE])
            || $past(reg_wr_in) || $past(ev_a[0][BIT_BDE]));
    endproperty
    a_map: assert property (p_map) else $error("deskew event not at bit 4");

    property p_en_reset;
        @(posedge clk_in) disable iff (1'b0)
        !rst_n_in |=> en_a_r == '0 && en_b_r == '0;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enables not zero after reset");

    property p_thresh_below;
        bde_count_in[0] < error_count_threshold_in && !st_a_r[0][BIT_BDE] |=> !st_a_r[0][BIT_BDE];
    endproperty
    a_thresh_below: assert property (p_thresh_below) else $error("flag below threshold");

    property p_thresh_reach;
        en_a_r[0][BIT_BDE] && bde_count_in[0] >= error_count_threshold_in && !lvl_r[0][BIT_BDE]
            |=> st_a_r[0][BIT_BDE];
    endproperty
    a_thresh_reach: assert property (p_thresh_reach) else $error("threshold reach missed");

    property p_pin_route;
        irq_any |=> (interrupt_pin_second_out == $past(pin_sel_r))
            && (interrupt_pin_first_out == !$past(pin_sel_r));
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("interrupt on wrong pin");

    sequence s_cgs_event0;
        ev_a[0][BIT_CGS] && en_a_r[0][BIT_CGS] && !reg_wr_in;
    endsequence

    property p_latch_irq;
        s_cgs_event0 |=> st_a_r[0][BIT_CGS]
            ##1 (interrupt_pin_first_out || interrupt_pin_second_out);
    endproperty
    a_latch_irq: assert property (p_latch_irq) else $error("enabled event not latched");

    property p_cfg_latch;
        ev_b[0] && en_b_r[0] |=> st_b_r[0];
    endproperty
    a_cfg_latch: assert property (p_cfg_latch) else $error("mismatch not latched");
endmodule // slie_irq_core
`default_nettype wire

// >>> testbench/slie_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module slie_tx_model (
    input  wire logic                        clk_in,
    input  wire logic                        start_in,
    input  wire logic [2:0]                  lane_in,
    input  wire logic [slie_pkg::LINK_W-1:0] link_in,
    input  wire slie_pkg::slie_ilas_t        params_in,
    input  wire logic                        bad_cks_in,
    output logic                             valid_out,
    output logic [2:0]                       lane_out,
    output logic [slie_pkg::LINK_W-1:0]      link_out,
    output logic [3:0]                       index_out,
    output logic [7:0]                       byte_out,
    output logic                             done_out
);
    import slie_pkg::*;
    logic       busy = 1'b0;
    logic [4:0] cnt  = 5'h00;
    slie_ilas_t buf_q;
    logic [7:0] cks;

    // Checksum sent with the alignment data, optionally spoiled
    always_comb begin
        cks = 8'h00;
        for (int i = 0; i < ILAS_LEN - 1; i++) begin
            cks = cks + params_in[i];
        end
        cks = cks ^ {7'h00, bad_cks_in};
    end

    initial begin
        valid_out = 1'b0;
        done_out  = 1'b0;
        byte_out  = 8'h00;
        index_out = 4'h0;
        lane_out  = 3'h0;
        link_out  = '0;
    end

    always @(posedge clk_in) begin
        valid_out <= 1'b0;
        done_out  <= 1'b0;
        byte_out  <= ~byte_out;
        if (!busy && start_in) begin
            busy                <= 1'b1;
            cnt                 <= 5'h00;
            buf_q               <= params_in;
            buf_q[ILAS_CKS_IDX] <= cks;
            lane_out            <= lane_in;
            link_out            <= link_in;
        end else if (busy) begin
            if (cnt < ILAS_LEN) begin
                valid_out <= 1'b1;
                index_out <= cnt[3:0];
                byte_out  <= buf_q[cnt];
                cnt       <= cnt + 5'h01;
            end else begin
                done_out <= 1'b1;
                busy     <= 1'b0;
            end
        end
    end
endmodule // slie_tx_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import slie_pkg::*;
    logic                          clk, rst_n, wr, rd, rvalid, pin0, pin1;
    logic [ADDR_W-1:0]             addr;
    logic [7:0]                    wdata, rdata, thr;
    logic [NUM_LINKS-1:0][7:0]     bde, nit, uek;
    logic [NUM_LINKS-1:0]          dsk, ls, fs, cgs;
    logic                          iv, idn, go, badc;
    logic [2:0]                    il, glane;
    logic [LINK_W-1:0]             ik, glink;
    logic [3:0]                    ix;
    logic [7:0]                    ib;
    slie_ilas_t                    par;
    int                            n_errors, num_checks;

    slie_irq_core i_slie_irq_core (.clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .error_count_threshold_in(thr), .bde_count_in(bde),
        .nit_count_in(nit), .uek_count_in(uek), .deskew_ok_in(dsk), .lane_sync_ok_in(ls),
        .frame_sync_ok_in(fs), .codegroup_sync_ok_in(cgs), .ilas_valid_in(iv),
        .ilas_lane_in(il), .ilas_link_in(ik), .ilas_index_in(ix), .ilas_byte_in(ib),
        .ilas_done_in(idn), .interrupt_pin_first_out(pin0), .interrupt_pin_second_out(pin1));
    slie_tx_model i_slie_tx_model (.clk_in(clk), .start_in(go), .lane_in(glane),
        .link_in(glink), .params_in(par), .bad_cks_in(badc), .valid_out(iv), .lane_out(il),
        .link_out(ik), .index_out(ix), .byte_out(ib), .done_out(idn));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wrr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1; addr = a; wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        int k;
        @(negedge clk);
        rd = 1'b1; addr = a;
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            rd = 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (k == 4) begin
            n_errors++;
            $display("[ERR] rvalid expected 1 seen 0");
            stop_test();
        end
        chk($sformatf("reg %h", a), rdata, exp);
    endtask

    task automatic pins(input logic e0, input logic e1);
        chk("pin_first", {7'h00, pin0}, {7'h00, e0});
        chk("pin_second", {7'h00, pin1}, {7'h00, e1});
    endtask

    task automatic src(input int b, input int l, input logic v);
        case (b)
            7: bde[l] = v ? thr : 8'h00;
            6: nit[l] = v ? thr : 8'h00;
            5: uek[l] = v ? thr : 8'h00;
            4: dsk[l] = v;
            3: ls[l]  = v;
            1: fs[l]  = v;
            default: cgs[l] = v;
        endcase
        w(4);
    endtask

    task automatic t_regs();
        rdc(ADDR_LINK_PAGE, 8'h00);
        rdc(ADDR_ST_B, 8'h00);
        rdc(ADDR_EN_A, 8'h00);
        rdc(ADDR_EN_B, 8'h00);
        rdc(ADDR_ST_A, 8'h00);
        rdc(ADDR_PIN_SEL, 8'h00);
        wrr(ADDR_EN_B, 8'hFF);
        rdc(ADDR_EN_B, 8'h01);
        wrr(12'h123, 8'hA5);
        rdc(12'h123, 8'h00);
        wrr(ADDR_EN_B, 8'h00);
    endtask

    task automatic t_events();
        wrr(ADDR_EN_A, 8'hFF);
        for (int b = 0; b < 8; b++) begin
            if (b == BIT_CKS) continue;
            src(b, 0, 1'b1);
            rdc(ADDR_ST_A, 8'h01 << b);
            pins(1'b1, 1'b0);
            src(b, 0, 1'b0);
            wrr(ADDR_ST_A, 8'h01 << b);
            w(3);
            pins(1'b0, 1'b0);
            rdc(ADDR_ST_A, 8'h00);
        end
        bde[0] = thr - 8'h01;
        w(4);
        rdc(ADDR_ST_A, 8'h00);
        bde[0] = thr;
        w(4);
        rdc(ADDR_ST_A, 8'h80);
        bde[0] = 8'h00;
        wrr(ADDR_ST_A, 8'hFF);
        wrr(ADDR_EN_A, 8'h00);
        src(1, 0, 1'b1);
        rdc(ADDR_ST_A, 8'h00);
        pins(1'b0, 1'b0);
        src(1, 0, 1'b0);
    endtask

    task automatic t_bank_route();
        wrr(ADDR_LINK_PAGE, 8'h01);
        rdc(ADDR_LINK_PAGE, 8'h01);
        wrr(ADDR_EN_A, 8'h02);
        src(1, 1, 1'b1);
        rdc(ADDR_ST_A, 8'h02);
        wrr(ADDR_LINK_PAGE, 8'h00);
        rdc(ADDR_ST_A, 8'h00);
        rdc(ADDR_EN_A, 8'h00);
        pins(1'b1, 1'b0);
        wrr(ADDR_PIN_SEL, 8'h01);
        w(3);
        pins(1'b0, 1'b1);
        wrr(ADDR_LINK_PAGE, 8'h01);
        wrr(ADDR_ST_A, 8'h02);
        w(3);
        pins(1'b0, 1'b0);
        src(1, 1, 1'b0);
        wrr(ADDR_LINK_PAGE, 8'h00);
        wrr(ADDR_PIN_SEL, 8'h00);
    endtask

    task automatic send(input logic [2:0] ln, input logic bad, input logic [7:0] ea,
                        input logic [7:0] eb);
        int k;
        @(negedge clk);
        go = 1'b1; glane = ln; glink = '0; badc = bad;
        @(negedge clk);
        go = 1'b0;
        for (k = 0; k < 40 && idn !== 1'b1; k++) @(negedge clk);
        if (k == 40) begin
            n_errors++;
            $display("[ERR] alignment done expected 1 seen 0");
            stop_test();
        end
        w(5);
        rdc(ADDR_ST_A, ea);
        rdc(ADDR_ST_B, eb);
        wrr(ADDR_ST_A, 8'hFF);
        wrr(ADDR_ST_B, 8'hFF);
    endtask

    task automatic t_ilas();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < ILAS_LEN - 1; i++) begin
            par[i] = 8'h11 + 8'(i * 3);
            s = s + par[i];
        end
        par[ILAS_CKS_IDX] = s;
        for (int i = 0; i < ILAS_LEN; i++) wrr(ADDR_ILAS_BASE + 12'(i), par[i]);
        wrr(ADDR_EN_A, 8'h04);
        wrr(ADDR_EN_B, 8'h01);
        send(3'h0, 1'b0, 8'h04, 8'h00);
        wrr(ADDR_ILAS_CKS, s ^ 8'hFF);
        send(3'h0, 1'b0, 8'h04, 8'h01);
        wrr(ADDR_ILAS_CKS, s);
        send(3'h0, 1'b1, 8'h00, 8'h01);
        send(3'h3, 1'b1, 8'h00, 8'h00);
    endtask

    initial begin
        n_errors = 0; num_checks = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = 8'h00; thr = 8'h10;
        bde = '0; nit = '0; uek = '0; dsk = '0; ls = '0; fs = '0; cgs = '0;
        go = 1'b0; glane = 3'h0; glink = '0; badc = 1'b0; par = '0;
        w(6);
        rst_n = 1'b1;
        w(1);
        pins(1'b0, 1'b0);
        t_regs();
        t_events();
        t_bank_route();
        t_ilas();
        stop_test();
    end
endmodule // tb
`default_nettype wire
